// [pin_mux_pkg.sv]
// Shared constants and carrier types for the pin multiplexer.
package pin_mux_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int TIMER_N = 4;
  localparam int IRQ_N = 2;
  localparam int BOOT_W = 3;
  localparam int IRQ_A = 0;
  localparam int IRQ_B = 1;

  localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_TIMER = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_DIR = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_OUT = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_IN = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CFG = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_MASK = 6'h1c;
  localparam logic [ADDR_W-1:0] OFF_BOOT = 6'h20;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic boot_done;
    logic mode_sel;
    logic host_sel;
  } ctrl_type;

  typedef struct packed {
    logic [TIMER_N-1:0] dir;
    logic [TIMER_N-1:0] sel;
  } timer_cfg_type;

  typedef struct packed {
    logic h0;
    logic [TIMER_N-1:0] g;
    logic b15;
  } gpio_type;

  localparam ctrl_type CTRL_RST = 3'h0;
  localparam timer_cfg_type TIMER_RST = 8'h00;
  localparam gpio_type GPIO_RST = 6'h00;
  localparam logic [IRQ_N-1:0] IRQ_CFG_RST = 2'h0;
  localparam logic [IRQ_N-1:0] MASK_RST = 2'h0;
  localparam logic [IRQ_N-1:0] STATUS_RST = 2'h0;
  localparam logic [BOOT_W-1:0] BOOT_RST = 3'h0;

endpackage

// [ext_irq_detect.sv]
// Synchroniser and level or falling-edge detector for one request input.
`timescale 1ns/1ps
module ext_irq_detect (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Raw request pin and detection mode.
  input wire logic req_raw_n,
  input wire logic edge_mode,
  // Detected request.
  output logic req
);

  logic sync1;
  logic sync2;
  logic sync3;
  logic next_req;

  always_comb begin
    if (edge_mode) begin
      next_req = sync3 & ~sync2;
    end else begin
      next_req = ~sync2;
    end
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
      req <= 1'b0;
    end else begin
      sync1 <= req_raw_n;
      sync2 <= sync1;
      sync3 <= sync2;
      req <= next_req;
    end
  end

  sequence s_fall;
    $fell(req_raw_n) ##0 edge_mode;
  endsequence

  sequence s_low_level;
    (!req_raw_n && !edge_mode) ##1 (!edge_mode)[*2];
  endsequence

  chk_edge_latency: assert property (@(posedge aclk)
    disable iff (!aresetn)
    s_fall ##1 edge_mode[*2] |=> req)
    else $error("falling edge not reported three cycles later");

  chk_level_latency: assert property (@(posedge aclk)
    disable iff (!aresetn)
    s_low_level |=> req)
    else $error("low level not reported three cycles later");

endmodule

// [host_timer_irq_boot_pin_mux.sv]
// Pin multiplexer for host handshake, timer, interrupt and boot pins.
// Functional notes
// - Host mode, request mode 0: pin feeds host acknowledge to host logic.
// - Host mode, request mode 1: pin is open-drain receive request output.
// - Host function off: pin is port B bit 15 general purpose I/O.
// - Host function off: host acknowledge input held disconnected.
// - Each timer pin separately feeds a timer input or drives a flag.
// - Timer pins unused by timers are port G bits 0-3, own direction.
// - Two external interrupt requests are accepted asynchronously.
// - Each request is level-sensitive or falling-edge triggered.
// - Boot pin A supplies one of three bits choosing eight boot modes.
// - After bootstrap, boot pin A becomes port H bit 0 I/O.
// - Boot mode is latched from three pins when reset is released.
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module host_timer_irq_boot_pin_mux (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [pin_mux_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [pin_mux_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels.
  input wire logic [pin_mux_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [pin_mux_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Interrupt output.
  output logic irq,
  // Shared host handshake pin.
  input wire logic host_pin_in,
  output logic host_pin_out,
  output logic host_pin_oe,
  // Host interface logic side.
  input wire logic host_rx_request_out,
  output logic host_ack_in,
  // Timer pins.
  input wire logic [pin_mux_pkg::TIMER_N-1:0] timer_pin_in,
  output logic [pin_mux_pkg::TIMER_N-1:0] timer_pin_out,
  output logic [pin_mux_pkg::TIMER_N-1:0] timer_pin_oe,
  // Timer logic side.
  input wire logic [pin_mux_pkg::TIMER_N-1:0] timer_flag,
  output logic [pin_mux_pkg::TIMER_N-1:0] timer_src,
  // External interrupt request pins, active low.
  input wire logic ext_int_req_a_n,
  input wire logic ext_int_req_b_n,
  // Boot mode pins.
  input wire logic boot_mode_pin_a_in,
  output logic boot_mode_pin_a_out,
  output logic boot_mode_pin_a_oe,
  input wire logic boot_mode_pin_b,
  input wire logic boot_mode_pin_c,
  // Boot state.
  output logic [pin_mux_pkg::BOOT_W-1:0] boot_mode,
  output logic boot_done
);

  import pin_mux_pkg::*;

  ctrl_type ctrl;
  ctrl_type next_ctrl;
  timer_cfg_type tcfg;
  timer_cfg_type next_tcfg;
  gpio_type gdir;
  gpio_type next_gdir;
  gpio_type gout;
  gpio_type next_gout;
  gpio_type gin;
  logic [IRQ_N-1:0] icfg;
  logic [IRQ_N-1:0] next_icfg;
  logic [IRQ_N-1:0] status;
  logic [IRQ_N-1:0] next_status;
  logic [IRQ_N-1:0] mask;
  logic [IRQ_N-1:0] next_mask;
  logic [IRQ_N-1:0] irq_hit;
  logic [IRQ_N-1:0] irq_raw_n;
  logic [IRQ_N-1:0] clr;
  logic aw_full;
  logic next_aw_full;
  logic w_full;
  logic next_w_full;
  logic [ADDR_W-1:0] waddr;
  logic [ADDR_W-1:0] next_waddr;
  logic [DATA_W-1:0] wdat;
  logic [DATA_W-1:0] next_wdat;
  logic [3:0] wstb;
  logic [3:0] next_wstb;
  logic next_awready;
  logic next_wready;
  logic [1:0] next_bresp;
  logic next_bvalid;
  logic next_arready;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;
  logic next_irq;

  assign irq_raw_n = {ext_int_req_b_n, ext_int_req_a_n};
  assign gin = {boot_mode_pin_a_in, timer_pin_in, host_pin_in};

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_N; gi++) begin : g_irq
      ext_irq_detect u_det (
        .aclk(aclk),
        .aresetn(aresetn),
        .req_raw_n(irq_raw_n[gi]),
        .edge_mode(icfg[gi]),
        .req(irq_hit[gi])
      );
    end
  endgenerate

  // Register bus, configuration and interrupt status.
  always_comb begin
    next_ctrl = ctrl;
    next_tcfg = tcfg;
    next_gdir = gdir;
    next_gout = gout;
    next_icfg = icfg;
    next_mask = mask;
    clr = '0;
    next_aw_full = aw_full | (awvalid & awready);
    next_w_full = w_full | (wvalid & wready);
    next_waddr = (awvalid && awready) ? awaddr : waddr;
    next_wdat = (wvalid && wready) ? wdata : wdat;
    next_wstb = (wvalid && wready) ? wstrb : wstb;
    next_bvalid = bvalid & ~bready;
    next_bresp = bresp;
    if (aw_full && w_full && !bvalid) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (waddr)
        OFF_CTRL: begin
          if (wstb[0]) begin
            next_ctrl.host_sel = wdat[0];
            next_ctrl.mode_sel = wdat[1];
            next_ctrl.boot_done = ctrl.boot_done | wdat[2];
          end
        end
        OFF_TIMER: begin
          if (wstb[0]) begin
            next_tcfg = timer_cfg_type'(wdat[7:0]);
          end
        end
        OFF_DIR: begin
          if (wstb[0]) begin
            next_gdir = gpio_type'(wdat[5:0]);
          end
        end
        OFF_OUT: begin
          if (wstb[0]) begin
            next_gout = gpio_type'(wdat[5:0]);
          end
        end
        OFF_IRQ_CFG: begin
          if (wstb[0]) begin
            next_icfg = wdat[IRQ_N-1:0];
          end
        end
        OFF_STATUS: begin
          if (wstb[0]) begin
            clr = wdat[IRQ_N-1:0];
          end
        end
        OFF_MASK: begin
          if (wstb[0]) begin
            next_mask = wdat[IRQ_N-1:0];
          end
        end
        OFF_IN, OFF_BOOT: begin
          next_bresp = RESP_OKAY;
        end
        default: begin
          next_bresp = RESP_SLVERR;
        end
      endcase
    end
    next_awready = ~next_aw_full;
    next_wready = ~next_w_full;
    // A new event wins over a clear written in the same cycle.
    next_status = (status & ~clr) | irq_hit;
    next_irq = |(next_status & next_mask);
    next_rvalid = rvalid & ~rready;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      case (araddr)
        OFF_CTRL: next_rdata = DATA_W'(ctrl);
        OFF_TIMER: next_rdata = DATA_W'(tcfg);
        OFF_DIR: next_rdata = DATA_W'(gdir);
        OFF_OUT: next_rdata = DATA_W'(gout);
        OFF_IN: next_rdata = DATA_W'(gin);
        OFF_IRQ_CFG: next_rdata = DATA_W'(icfg);
        OFF_STATUS: next_rdata = DATA_W'(status);
        OFF_MASK: next_rdata = DATA_W'(mask);
        OFF_BOOT: next_rdata = DATA_W'({ctrl.boot_done, boot_mode});
        default: begin
          next_rdata = '0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RST;
      tcfg <= TIMER_RST;
      gdir <= GPIO_RST;
      gout <= GPIO_RST;
      icfg <= IRQ_CFG_RST;
      mask <= MASK_RST;
      status <= STATUS_RST;
      irq <= 1'b0;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      waddr <= '0;
      wdat <= '0;
      wstb <= '0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      ctrl <= next_ctrl;
      tcfg <= next_tcfg;
      gdir <= next_gdir;
      gout <= next_gout;
      icfg <= next_icfg;
      mask <= next_mask;
      status <= next_status;
      irq <= next_irq;
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      waddr <= next_waddr;
      wdat <= next_wdat;
      wstb <= next_wstb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // Pin routing.
  logic next_host_out;
  logic next_host_oe;
  logic next_host_ack;
  logic [TIMER_N-1:0] next_timer_out;
  logic [TIMER_N-1:0] next_timer_oe;
  logic [TIMER_N-1:0] next_timer_src;
  logic next_h0_out;
  logic next_h0_oe;

  always_comb begin
    next_host_ack = 1'b0;
    next_host_out = gout.b15;
    next_host_oe = gdir.b15;
    if (ctrl.host_sel) begin
      if (ctrl.mode_sel) begin
        // Open drain: only ever pulled low.
        next_host_out = 1'b0;
        next_host_oe = host_rx_request_out;
      end else begin
        next_host_out = 1'b0;
        next_host_oe = 1'b0;
        next_host_ack = host_pin_in;
      end
    end
    next_timer_oe = (tcfg.sel & tcfg.dir) | (~tcfg.sel & gdir.g);
    next_timer_out = (tcfg.sel & timer_flag) | (~tcfg.sel & gout.g);
    next_timer_src = tcfg.sel & ~tcfg.dir & timer_pin_in;
    next_h0_out = ctrl.boot_done & gout.h0;
    next_h0_oe = ctrl.boot_done & gdir.h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_pin_out <= 1'b0;
      host_pin_oe <= 1'b0;
      host_ack_in <= 1'b0;
      timer_pin_out <= '0;
      timer_pin_oe <= '0;
      timer_src <= '0;
      boot_mode_pin_a_out <= 1'b0;
      boot_mode_pin_a_oe <= 1'b0;
      boot_done <= 1'b0;
    end else begin
      host_pin_out <= next_host_out;
      host_pin_oe <= next_host_oe;
      host_ack_in <= next_host_ack;
      timer_pin_out <= next_timer_out;
      timer_pin_oe <= next_timer_oe;
      timer_src <= next_timer_src;
      boot_mode_pin_a_out <= next_h0_out;
      boot_mode_pin_a_oe <= next_h0_oe;
      boot_done <= ctrl.boot_done;
    end
  end

  // Boot mode capture at the first edge after reset release.
  logic boot_captured;
  logic next_boot_captured;
  logic [BOOT_W-1:0] next_boot_mode;

  always_comb begin
    next_boot_captured = 1'b1;
    next_boot_mode = boot_mode;
    if (!boot_captured) begin
      next_boot_mode = {boot_mode_pin_c, boot_mode_pin_b,
        boot_mode_pin_a_in};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_captured <= 1'b0;
      boot_mode <= BOOT_RST;
    end else begin
      boot_captured <= next_boot_captured;
      boot_mode <= next_boot_mode;
    end
  end

  sequence s_boot_end;
    !ctrl.boot_done ##1 ctrl.boot_done;
  endsequence

  chk_ack_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl.host_sel && !ctrl.mode_sel) |=>
      host_ack_in == $past(host_pin_in) && !host_pin_oe)
    else $error("host acknowledge not routed from pin");

  chk_request_drive: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (ctrl.host_sel && ctrl.mode_sel && host_rx_request_out) |=>
      host_pin_oe && !host_pin_out)
    else $error("receive request not pulling the pin low");

  chk_port_b15: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl.host_sel |=> host_pin_oe == $past(gdir.b15)
      && host_pin_out == $past(gout.b15))
    else $error("port B bit 15 not following its registers");

  chk_ack_isolate: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !ctrl.host_sel |=> !host_ack_in)
    else $error("host acknowledge leaks in general purpose mode");

  chk_timer_input: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (tcfg.sel[0] && !tcfg.dir[0]) |=>
      !timer_pin_oe[0] && timer_src[0] == $past(timer_pin_in[0]))
    else $error("timer pin 0 not feeding the timer input");

  chk_timer_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (tcfg.sel[3] && tcfg.dir[3]) |=>
      timer_pin_oe[3] && timer_pin_out[3] == $past(timer_flag[3]))
    else $error("timer pin 3 not driving the output flag");

  chk_port_g_dir: assert property (@(posedge aclk) disable iff (!aresetn)
    !tcfg.sel[1] |=> timer_pin_oe[1] == $past(gdir.g[1])
      && !timer_src[1])
    else $error("port G bit 1 direction not honoured");

  chk_boot_latch: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !boot_captured |=> boot_captured && boot_mode ==
      $past({boot_mode_pin_c, boot_mode_pin_b, boot_mode_pin_a_in}))
    else $error("boot mode not latched at reset release");

  chk_port_h_gate: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !ctrl.boot_done |=> !boot_mode_pin_a_oe)
    else $error("boot pin A driven before bootstrap ends");

  chk_port_h_after: assert property (@(posedge aclk)
    disable iff (!aresetn)
    s_boot_end |=> boot_mode_pin_a_oe == $past(gdir.h0))
    else $error("port H bit 0 not released after bootstrap");

  chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(status & mask))
    else $error("interrupt output disagrees with status and mask");

endmodule

// [pin_far_side.sv]
// Far-side model: outside drivers on shared pins and interrupt sources.
`timescale 1ns/1ps
module pin_far_side (
  // Device pin drivers.
  input wire logic host_pin_out,
  input wire logic host_pin_oe,
  input wire logic [3:0] timer_pin_out,
  input wire logic [3:0] timer_pin_oe,
  input wire logic boot_a_out,
  input wire logic boot_a_oe,
  // Levels the outside world puts on released pins.
  input wire logic ext_host,
  input wire logic [3:0] ext_timer,
  input wire logic ext_boot,
  input wire logic req_a_low,
  input wire logic req_b_low,
  // Resolved pin levels.
  output logic host_pin_in,
  output logic [3:0] timer_pin_in,
  output logic boot_a_in,
  output logic req_a_n,
  output logic req_b_n
);
  assign host_pin_in = host_pin_oe ? host_pin_out : ext_host;
  assign timer_pin_in = (timer_pin_oe & timer_pin_out) |
                        (~timer_pin_oe & ext_timer);
  assign boot_a_in = boot_a_oe ? boot_a_out : ext_boot;
  // Requests move off the clock grid, as an unrelated source would.
  assign #13 req_a_n = ~req_a_low;
  assign #13 req_b_n = ~req_b_low;
endmodule

// [host_timer_irq_boot_pin_mux_tb.sv]
// Self-checking testbench for the pin multiplexer.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module host_timer_irq_boot_pin_mux_tb;
  import pin_mux_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic host_pin_in, host_pin_out, host_pin_oe, host_ack_in;
  logic host_rx_request_out = 1'b0, ext_host = 1'b1;
  logic [3:0] timer_pin_in, timer_pin_out, timer_pin_oe, timer_src;
  logic [3:0] timer_flag = 4'h0, ext_timer = 4'h0;
  logic req_a_n, req_b_n, req_a_low = 1'b0, req_b_low = 1'b0;
  logic boot_a_in, boot_a_out, boot_a_oe, boot_done;
  logic ext_boot = 1'b1, boot_b = 1'b0, boot_c = 1'b1;
  logic [BOOT_W-1:0] boot_mode;
  int err_total = 0;
  int checks_done = 0;

  always #20 aclk = ~aclk;

  host_timer_irq_boot_pin_mux DUT (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq), .host_pin_in(host_pin_in),
    .host_pin_out(host_pin_out), .host_pin_oe(host_pin_oe),
    .host_rx_request_out(host_rx_request_out), .host_ack_in(host_ack_in),
    .timer_pin_in(timer_pin_in), .timer_pin_out(timer_pin_out),
    .timer_pin_oe(timer_pin_oe), .timer_flag(timer_flag),
    .timer_src(timer_src), .ext_int_req_a_n(req_a_n),
    .ext_int_req_b_n(req_b_n), .boot_mode_pin_a_in(boot_a_in),
    .boot_mode_pin_a_out(boot_a_out), .boot_mode_pin_a_oe(boot_a_oe),
    .boot_mode_pin_b(boot_b), .boot_mode_pin_c(boot_c),
    .boot_mode(boot_mode), .boot_done(boot_done));

  pin_far_side far (.host_pin_out(host_pin_out), .host_pin_oe(host_pin_oe),
    .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe),
    .boot_a_out(boot_a_out), .boot_a_oe(boot_a_oe), .ext_host(ext_host),
    .ext_timer(ext_timer), .ext_boot(ext_boot), .req_a_low(req_a_low),
    .req_b_low(req_b_low), .host_pin_in(host_pin_in),
    .timer_pin_in(timer_pin_in), .boot_a_in(boot_a_in), .req_a_n(req_a_n),
    .req_b_n(req_b_n));

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic timeout;
    err_total++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    print_verdict();
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Write one word and compare the response code.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 50) timeout();
    `CHK(bresp, er)
  endtask

  task automatic rdw(input logic [ADDR_W-1:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 50) timeout();
    rd = rdata;
    resp = rresp;
  endtask

  task automatic t_boot_latch;
    ext_boot <= 1'b0;
    wait_cyc(3);
    `CHK(boot_mode, 3'h5)
    rdw(OFF_BOOT);
    `CHK(rd[3:0], 4'h5)
  endtask

  task automatic t_host_gpio;
    ext_host <= 1'b1;
    wait_cyc(3);
    `CHK(host_ack_in, 1'b0)
    rdw(OFF_IN);
    `CHK(rd[0], 1'b1)
    wr(OFF_DIR, 32'h1, RESP_OKAY);
    wait_cyc(3);
    `CHK({host_pin_oe, host_pin_out}, 2'h2)
    wr(OFF_DIR, 32'h0, RESP_OKAY);
  endtask

  task automatic t_host_modes;
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    ext_host <= 1'b0;
    wait_cyc(3);
    `CHK({host_pin_oe, host_ack_in}, 2'h0)
    ext_host <= 1'b1;
    wait_cyc(3);
    `CHK({host_pin_oe, host_ack_in}, 2'h1)
    wr(OFF_CTRL, 32'h3, RESP_OKAY);
    host_rx_request_out <= 1'b1;
    wait_cyc(3);
    `CHK({host_pin_oe, host_pin_out}, 2'h2)
    host_rx_request_out <= 1'b0;
    wait_cyc(3);
    `CHK(host_pin_oe, 1'b0)
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
  endtask

  task automatic t_timers;
    wr(OFF_TIMER, 32'h5f, RESP_OKAY);
    timer_flag <= 4'hf;
    ext_timer <= 4'ha;
    wait_cyc(3);
    `CHK(timer_pin_oe, 4'h5)
    `CHK(timer_pin_out & 4'h5, 4'h5)
    `CHK(timer_src & 4'ha, 4'ha)
    timer_flag <= 4'h0;
    wait_cyc(3);
    `CHK(timer_pin_out & 4'h5, 4'h0)
    wr(OFF_TIMER, 32'h0, RESP_OKAY);
    wr(OFF_DIR, 32'h14, RESP_OKAY);
    wr(OFF_OUT, 32'h10, RESP_OKAY);
    ext_timer <= 4'h5;
    wait_cyc(3);
    `CHK(timer_pin_oe, 4'ha)
    `CHK(timer_pin_out & 4'ha, 4'h8)
    rdw(OFF_IN);
    `CHK(rd[4:1], 4'hd)
  endtask

  task automatic t_irq;
    wr(OFF_MASK, 32'h3, RESP_OKAY);
    wr(OFF_IRQ_CFG, 32'h1, RESP_OKAY);
    req_a_low <= 1'b1;
    wait_cyc(6);
    `CHK(irq, 1'b1)
    wr(OFF_STATUS, 32'h1, RESP_OKAY);
    wait_cyc(6);
    rdw(OFF_STATUS);
    `CHK({irq, rd[1:0]}, 3'h0)
    req_a_low <= 1'b0;
    req_b_low <= 1'b1;
    wait_cyc(6);
    wr(OFF_STATUS, 32'h2, RESP_OKAY);
    wait_cyc(6);
    rdw(OFF_STATUS);
    `CHK({irq, rd[1:0]}, 3'h6)
    req_b_low <= 1'b0;
    wait_cyc(6);
    wr(OFF_STATUS, 32'h2, RESP_OKAY);
    wr(OFF_MASK, 32'h0, RESP_OKAY);
    req_b_low <= 1'b1;
    wait_cyc(6);
    rdw(OFF_STATUS);
    `CHK({irq, rd[1:0]}, 3'h2)
    req_b_low <= 1'b0;
    wait_cyc(6);
    wr(OFF_STATUS, 32'h2, RESP_OKAY);
  endtask

  task automatic t_boot_done;
    wr(OFF_DIR, 32'h20, RESP_OKAY);
    wr(OFF_OUT, 32'h20, RESP_OKAY);
    wait_cyc(3);
    `CHK(boot_a_oe, 1'b0)
    wr(OFF_CTRL, 32'h4, RESP_OKAY);
    wait_cyc(3);
    `CHK({boot_done, boot_a_oe, boot_a_out}, 3'h7)
    rdw(OFF_BOOT);
    `CHK(rd[3:0], 4'hd)
    rdw(6'h24);
    `CHK({resp, rd}, {RESP_SLVERR, 32'h0})
    wr(6'h24, 32'h1, RESP_SLVERR);
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_boot_latch();
    t_host_gpio();
    t_host_modes();
    t_timers();
    t_irq();
    t_boot_done();
    print_verdict();
  end
endmodule
